// *** hw/ast_top.sv ***
// Purpose: Full-duplex asynchronous serial transceiver with an AXI4-Lite register slave.
// Assumes: rx_pin is asynchronous; the core clock doubles as the module clock.
// Notes: tx_oe low hands the transmit pin back to general port logic.
// Function
// - Frame is start, eight or nine data bits, stop: 10 or 11 bits.
// - Transmit ninth bit keeps its value after each transmission.
// - A 13-bit modulus counter divides the clock by the programmed divisor.
// - Divided tick samples receiver 16 per bit; transmitter runs at tick over 16.
// - Enable rising loads a preamble of 10 or 11 ones before buffered data; a rise on a transmit tick sends the data first.
// - Loading data inserts a 0 start bit low and a 1 stop bit high.
// - Odd or even parity replaces the top data bit when enabled.
// - Empty flag sets on buffer transfer; with its enable it requests interrupt.
// - Transmit pin is 1 whenever no frame is shifting.
// - Enable cleared mid-frame finishes the frame, then releases the pin.
// - Clearing then setting enable mid-frame queues one idle character.
// - While send-break is set, all-zero break characters of frame length repeat.
// - After break clears, finish the break and send at least one 1.
// - Break reception sets framing error and full flags, clears data.
// - Idle character is all ones of frame length; the preamble is one.
// - Complete frame moves data to buffer, sets full flag, maybe interrupt.
// - Received ninth bit appears in the high data register.
// - Data registers write the transmit buffer and read the receive buffer.
// - Start is 0 after three 1 samples, verified at samples 3, 5, 7.
// - Data bit is majority of samples 8, 9, 10; disagreement flags noise.
// - Stop bit majority zero is framing error; disagreement flags noise.
`timescale 1ns/1ps
module ast_top
	import ast_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// AXI4-Lite slave
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Serial line
	input wire logic rx_pin,
	output logic tx_pin,
	output logic tx_oe,
	// Interrupt request level
	output logic irq
);
	// ==========================================================
	// Register state
	logic [12:0] baud_divisor_reg;
	ast_fmt_t fmt_reg;
	logic [7:0] ctrl2_reg;
	logic [7:0] tx_buf_reg;
	logic tx_ninth_bit_reg;
	logic tx_buf_empty_flag_reg;
	logic [7:0] rx_buf_reg;
	logic rx_ninth_bit_reg;
	logic rx_buf_full_flag_reg;
	logic framing_err_flag_reg;
	logic noise_flag_reg;
	logic parity_err_flag_reg;
	logic stat_read_reg;
	logic tx_done;
	logic rx_active_flag;
	logic tx_enable;
	assign tx_enable = ctrl2_reg[AST_C2_TX_EN];

	// ==========================================================
	// AXI4-Lite handshake
	logic [7:0] aw_reg;
	logic aw_full_reg;
	logic [31:0] w_reg;
	logic w_full_reg;
	logic do_write;
	logic do_read;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;
	assign s_awready = !aw_full_reg;
	assign s_wready = !w_full_reg;
	assign do_write = aw_full_reg && w_full_reg && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign do_read = s_arvalid && s_arready;
	assign wr_hit = aw_reg <= AST_DATAL_OFF && aw_reg[1:0] == 2'h0;
	assign rd_hit = s_araddr <= AST_DATAL_OFF && s_araddr[1:0] == 2'h0;
	wire wr_data_lo = do_write && aw_reg == AST_DATAL_OFF;
	wire rd_data_lo = do_read && s_araddr == AST_DATAL_OFF;
	wire rd_stat1 = do_read && s_araddr == AST_STAT1_OFF;
	wire wr_ctrl2 = do_write && aw_reg == AST_CTRL2_OFF;

	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_araddr)
			AST_BAUD_OFF: rd_word = {19'h00000, baud_divisor_reg};
			AST_CTRL1_OFF: rd_word = {27'h0, fmt_reg.len9, 2'h0, fmt_reg.par_en, fmt_reg.par_odd};
			AST_CTRL2_OFF: rd_word = {24'h0, ctrl2_reg};
			AST_STAT1_OFF: rd_word = {24'h0, tx_buf_empty_flag_reg, tx_done, rx_buf_full_flag_reg,
				2'h0, noise_flag_reg, framing_err_flag_reg, parity_err_flag_reg};
			AST_STAT2_OFF: rd_word = {31'h0, rx_active_flag};
			AST_DATAH_OFF: rd_word = {24'h0, rx_ninth_bit_reg, tx_ninth_bit_reg, 6'h00};
			AST_DATAL_OFF: rd_word = {24'h0, rx_buf_reg};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_reg <= 8'h00;
			w_reg <= 32'h0000_0000;
			s_bvalid <= 1'b0;
			s_bresp <= AST_RESP_OKAY;
			s_rvalid <= 1'b0;
			s_rresp <= AST_RESP_OKAY;
			s_rdata <= 32'h0000_0000;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_full_reg <= 1'b1;
				aw_reg <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_full_reg <= 1'b1;
				w_reg <= s_wdata;
			end
			if (do_write) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wr_hit ? AST_RESP_OKAY : AST_RESP_SLVERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
			if (do_read) begin
				s_rvalid <= 1'b1;
				s_rdata <= rd_word;
				s_rresp <= rd_hit ? AST_RESP_OKAY : AST_RESP_SLVERR;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Baud generator
	logic [12:0] div_cnt_reg;
	logic [3:0] tx_div_reg;
	logic tick;
	logic tx_tick;
	// A divisor of zero stops the generator, leaving both directions frozen.
	assign tick = baud_divisor_reg != 13'h0000 && div_cnt_reg == baud_divisor_reg - 13'h0001;
	assign tx_tick = tick && tx_div_reg == AST_SUB_LAST;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			div_cnt_reg <= 13'h0000;
			tx_div_reg <= 4'h0;
		end else begin
			div_cnt_reg <= (tick || baud_divisor_reg == 13'h0000) ? 13'h0000 : div_cnt_reg + 13'h0001;
			if (tick) begin
				tx_div_reg <= tx_div_reg + 4'h1;
			end
		end
	end

	// ==========================================================
	// Transmitter
	ast_tx_state_t tx_state_reg;
	logic [10:0] tx_shift_reg;
	logic [3:0] tx_left_reg;
	logic pre_pend_reg;
	logic brk_tail_reg;
	logic te_d_reg;
	logic tx_own_reg;
	logic tx_par;
	logic [8:0] tx_char;
	logic [3:0] frame_len;
	logic [10:0] tx_frame;
	logic te_rise;
	assign frame_len = fmt_reg.len9 ? 4'hb : 4'ha;
	assign te_rise = tx_enable && !te_d_reg;
	assign tx_par = ^{fmt_reg.len9 ? {tx_ninth_bit_reg, tx_buf_reg[7:0]} : {1'b0, tx_buf_reg}}
		^ fmt_reg.par_odd;
	always_comb begin
		tx_char = {tx_ninth_bit_reg, tx_buf_reg};
		if (fmt_reg.par_en) begin
			if (fmt_reg.len9) begin
				tx_char[8] = ^tx_buf_reg ^ fmt_reg.par_odd;
			end else begin
				tx_char[7] = ^tx_buf_reg[6:0] ^ fmt_reg.par_odd;
			end
		end
		tx_frame = fmt_reg.len9 ? {1'b1, tx_char, 1'b0} : {1'b1, 1'b1, tx_char[7:0], 1'b0};
	end
	assign tx_done = tx_state_reg == AST_TX_IDLE && tx_buf_empty_flag_reg;
	assign tx_pin = tx_state_reg == AST_TX_SHIFT ? tx_shift_reg[0] : 1'b1;
	assign tx_oe = tx_own_reg;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tx_state_reg <= AST_TX_IDLE;
			tx_shift_reg <= 11'h7ff;
			tx_left_reg <= 4'h0;
			pre_pend_reg <= 1'b0;
			brk_tail_reg <= 1'b0;
			te_d_reg <= 1'b0;
			tx_own_reg <= 1'b0;
			tx_buf_empty_flag_reg <= 1'b1;
		end else begin
			te_d_reg <= tx_enable;
			if (te_rise) begin
				pre_pend_reg <= 1'b1;
			end
			if (wr_data_lo && stat_read_reg) begin
				tx_buf_empty_flag_reg <= 1'b0;
			end
			if (tx_enable) begin
				tx_own_reg <= 1'b1;
			end else if (tx_state_reg == AST_TX_IDLE) begin
				tx_own_reg <= 1'b0;
			end
			case (tx_state_reg)
				AST_TX_IDLE: begin
					if (tx_tick && tx_enable) begin
						tx_state_reg <= AST_TX_SHIFT;
						tx_left_reg <= frame_len;
						// Break goes first so that it repeats for as long as it is requested.
						if (ctrl2_reg[AST_C2_BRK]) begin
							tx_shift_reg <= 11'h000;
							brk_tail_reg <= 1'b1;
						end else if (pre_pend_reg || brk_tail_reg) begin
							tx_shift_reg <= 11'h7ff;
							pre_pend_reg <= te_rise;
							brk_tail_reg <= 1'b0;
						end else if (!tx_buf_empty_flag_reg) begin
							tx_shift_reg <= tx_frame;
							tx_buf_empty_flag_reg <= 1'b1;
						end else begin
							tx_state_reg <= AST_TX_IDLE;
						end
					end
				end
				AST_TX_SHIFT: begin
					if (tx_tick) begin
						tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
						tx_left_reg <= tx_left_reg - 4'h1;
						if (tx_left_reg == 4'h1) begin
							tx_state_reg <= AST_TX_IDLE;
						end
					end
				end
				default: tx_state_reg <= AST_TX_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Receiver
	logic rx_s1_reg;
	logic rx_s2_reg;
	ast_rx_state_t rx_state_reg;
	logic [2:0] ones_reg;
	logic [3:0] sub_reg;
	logic [3:0] bit_reg;
	logic [2:0] vote_reg;
	logic [9:0] rx_shift_reg;
	logic frame_noise_reg;
	logic vote_bit;
	logic vote_noise;
	logic [3:0] data_bits;
	assign rx_active_flag = rx_state_reg != AST_RX_HUNT;
	assign data_bits = fmt_reg.len9 ? 4'h9 : 4'h8;
	assign vote_bit = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & rx_s2_reg)
		| (vote_reg[1] & rx_s2_reg);
	assign vote_noise = !(vote_reg[1:0] == {2{rx_s2_reg}});
	wire [8:0] rx_data = fmt_reg.len9 ? rx_shift_reg[9:1] : {1'b0, rx_shift_reg[9:2]};
	wire rx_en = ctrl2_reg[AST_C2_RX_EN];

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_state_reg <= AST_RX_HUNT;
			ones_reg <= 3'h0;
			sub_reg <= 4'h0;
			bit_reg <= 4'h0;
			vote_reg <= 3'h0;
			rx_shift_reg <= 10'h000;
			frame_noise_reg <= 1'b0;
		end else begin
			rx_s1_reg <= rx_pin;
			rx_s2_reg <= rx_s1_reg;
			if (tick) begin
				sub_reg <= sub_reg + 4'h1;
				case (rx_state_reg)
					AST_RX_HUNT: begin
						ones_reg <= rx_s2_reg ? (ones_reg == 3'h3 ? ones_reg : ones_reg + 3'h1) : 3'h0;
						if (!rx_s2_reg && ones_reg == 3'h3 && rx_en) begin
							rx_state_reg <= AST_RX_START;
							sub_reg <= 4'h2;
							frame_noise_reg <= 1'b0;
						end
					end
					AST_RX_START: begin
						if (sub_reg == 4'h3 || sub_reg == 4'h5) begin
							vote_reg <= {vote_reg[1:0], rx_s2_reg};
						end
						if (sub_reg == 4'h7) begin
							if ((vote_reg[1] & vote_reg[0]) | (vote_reg[1] & rx_s2_reg)
								| (vote_reg[0] & rx_s2_reg)) begin
								rx_state_reg <= AST_RX_HUNT;
								ones_reg <= 3'h0;
							end else if (vote_noise) begin
								frame_noise_reg <= 1'b1;
							end
						end
						if (sub_reg == 4'h0) begin
							rx_state_reg <= AST_RX_DATA;
							sub_reg <= 4'h1;
							bit_reg <= 4'h0;
						end
					end
					AST_RX_DATA: begin
						if (sub_reg == 4'h8 || sub_reg == 4'h9) begin
							vote_reg <= {vote_reg[1:0], rx_s2_reg};
						end
						if (sub_reg == 4'ha) begin
							rx_shift_reg <= {vote_bit, rx_shift_reg[9:1]};
							frame_noise_reg <= frame_noise_reg | vote_noise;
							bit_reg <= bit_reg + 4'h1;
							if (bit_reg == data_bits) begin
								rx_state_reg <= AST_RX_HUNT;
								ones_reg <= 3'h0;
							end
						end
						// Sixteen sub-bit ticks per bit; a shorter count would drift.
						if (sub_reg == 4'h0) begin
							sub_reg <= 4'h1;
						end
					end
					default: rx_state_reg <= AST_RX_HUNT;
				endcase
			end
		end
	end

	wire rx_done = tick && rx_state_reg == AST_RX_DATA && sub_reg == 4'ha && bit_reg == data_bits;
	wire rx_ferr = !vote_bit;
	wire [8:0] rx_word = rx_done ? {vote_bit, rx_shift_reg[9:2]} : 9'h000;
	wire [8:0] rx_final = fmt_reg.len9 ? {rx_shift_reg[9], rx_shift_reg[8:1]} : {1'b0, rx_word[7:0]};
	wire rx_par_bad = fmt_reg.par_en
		&& ((fmt_reg.len9 ? ^rx_shift_reg[9:1] : ^rx_shift_reg[9:2]) ^ fmt_reg.par_odd);
	wire rx_break = rx_ferr && rx_final == 9'h000;

	// ==========================================================
	// Registers written by software and flags
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			baud_divisor_reg <= AST_BAUD_RST;
			fmt_reg <= '0;
			ctrl2_reg <= 8'h00;
			tx_buf_reg <= 8'h00;
			tx_ninth_bit_reg <= 1'b0;
			rx_buf_reg <= 8'h00;
			rx_ninth_bit_reg <= 1'b0;
			rx_buf_full_flag_reg <= 1'b0;
			framing_err_flag_reg <= 1'b0;
			noise_flag_reg <= 1'b0;
			parity_err_flag_reg <= 1'b0;
			stat_read_reg <= 1'b0;
		end else begin
			if (do_write && s_wstrb[0]) begin
				case (aw_reg)
					AST_BAUD_OFF: baud_divisor_reg[7:0] <= w_reg[7:0];
					AST_CTRL1_OFF: fmt_reg <= {w_reg[AST_C1_LEN9], w_reg[AST_C1_PAR_EN],
						w_reg[AST_C1_PAR_ODD]};
					AST_CTRL2_OFF: ctrl2_reg <= w_reg[7:0];
					AST_DATAH_OFF: tx_ninth_bit_reg <= w_reg[AST_DH_TX9];
					AST_DATAL_OFF: tx_buf_reg <= w_reg[7:0];
					default: ;
				endcase
			end
			if (do_write && s_wstrb[1] && aw_reg == AST_BAUD_OFF) begin
				baud_divisor_reg[12:8] <= w_reg[12:8];
			end
			if (rd_stat1) begin
				stat_read_reg <= 1'b1;
			end else if (wr_data_lo) begin
				stat_read_reg <= 1'b0;
			end
			// Reading the data after a status read clears the receive flags; a new frame in that cycle wins.
			if (rd_data_lo && stat_read_reg) begin
				rx_buf_full_flag_reg <= 1'b0;
				framing_err_flag_reg <= 1'b0;
				noise_flag_reg <= 1'b0;
				parity_err_flag_reg <= 1'b0;
			end
			if (rx_done) begin
				rx_buf_full_flag_reg <= 1'b1;
				framing_err_flag_reg <= rx_ferr;
				noise_flag_reg <= frame_noise_reg | vote_noise;
				parity_err_flag_reg <= rx_par_bad;
				rx_buf_reg <= rx_break ? 8'h00 : rx_final[7:0];
				rx_ninth_bit_reg <= rx_break ? 1'b0 : (fmt_reg.len9 & rx_final[8]);
			end
		end
	end

	assign irq = (ctrl2_reg[AST_C2_TX_IRQ] && tx_buf_empty_flag_reg)
		|| (ctrl2_reg[AST_C2_RX_IRQ] && rx_buf_full_flag_reg);
	wire unused_ok = &{1'b0, tx_par, rx_data, wr_ctrl2, s_wstrb[3:2]};
endmodule

// *** hw/ast_pkg.sv ***
// Purpose: Shared constants and types for the asynchronous serial transceiver.
// Assumes: AXI4-Lite register access with 32-bit data, one register per word.
// Notes: Register offsets are byte addresses.
package ast_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] AST_BAUD_OFF = 8'h00;
	localparam logic [7:0] AST_CTRL1_OFF = 8'h04;
	localparam logic [7:0] AST_CTRL2_OFF = 8'h08;
	localparam logic [7:0] AST_STAT1_OFF = 8'h0c;
	localparam logic [7:0] AST_STAT2_OFF = 8'h10;
	localparam logic [7:0] AST_DATAH_OFF = 8'h14;
	localparam logic [7:0] AST_DATAL_OFF = 8'h18;
	// ==========================================================
	// Field positions
	localparam int AST_C1_LEN9 = 4;
	localparam int AST_C1_PAR_EN = 1;
	localparam int AST_C1_PAR_ODD = 0;
	localparam int AST_C2_TX_IRQ = 7;
	localparam int AST_C2_RX_IRQ = 5;
	localparam int AST_C2_TX_EN = 3;
	localparam int AST_C2_RX_EN = 2;
	localparam int AST_C2_BRK = 0;
	localparam int AST_DH_RX9 = 7;
	localparam int AST_DH_TX9 = 6;
	// ==========================================================
	// Reset values and widths
	localparam logic [12:0] AST_BAUD_RST = 13'h0004;
	localparam int AST_DIV_W = 13;
	localparam logic [3:0] AST_SUB_LAST = 4'hf;
	localparam logic [1:0] AST_RESP_OKAY = 2'h0;
	localparam logic [1:0] AST_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		AST_TX_IDLE = 2'b00,
		AST_TX_SHIFT = 2'b01
	} ast_tx_state_t;

	typedef enum logic [1:0] {
		AST_RX_HUNT = 2'b00,
		AST_RX_START = 2'b01,
		AST_RX_DATA = 2'b10
	} ast_rx_state_t;

	typedef struct packed {
		logic len9;
		logic par_en;
		logic par_odd;
	} ast_fmt_t;
endpackage

// *** dv/ast_chk.sv ***
// Purpose: Port-level checks on the serial transceiver.
// Assumes: One clock domain; sees only the top-level ports, bus and serial line.
// Notes: Bound into every ast_top instance below.
`timescale 1ns/1ps
module ast_chk
	import ast_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Register bus
	input wire logic [7:0] s_awaddr,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [7:0] s_araddr,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp,
	input wire logic s_rvalid,
	input wire logic s_rready,
	// Serial line
	input wire logic rx_pin,
	input wire logic tx_pin,
	input wire logic tx_oe,
	input wire logic irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// Register bus
	sequence wr_taken;
		s_awvalid && s_awready && s_wvalid && s_wready;
	endsequence
	sequence rd_taken;
		s_arvalid && s_arready;
	endsequence
	wr_answer_a: assert property (wr_taken |-> ##[1:2] s_bvalid)
		else $error("write response missing");
	b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
		else $error("write response dropped early");
	rd_answer_a: assert property (rd_taken |-> ##[1:2] s_rvalid)
		else $error("read response missing");
	r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read data dropped early");
	ar_refuse_a: assert property (s_rvalid |-> !s_arready)
		else $error("read taken while answer pending");
	unmapped_rd_a: assert property (rd_taken ##0 s_araddr > AST_DATAL_OFF
		|-> ##[1:2] (s_rvalid && s_rresp == AST_RESP_SLVERR))
		else $error("unmapped read not refused");
	// ==========================================================
	// Serial line
	start_bit_a: assert property ($fell(tx_pin) |-> !tx_pin [*8])
		else $error("short low bit on transmit pin");
	pin_owned_a: assert property (!tx_pin |-> tx_oe)
		else $error("transmit pin low while released");
	preamble_a: assert property ($rose(tx_oe) |-> tx_pin [*8])
		else $error("no idle preamble after enable");
endmodule
bind ast_top ast_chk chk (.*);

// *** dv/ast_remote.sv ***
// Purpose: Remote serial device on the far side of the line.
// Assumes: Same bit time as the transceiver, in core clocks.
// Notes: The line it drives idles high between frames.
`timescale 1ns/1ps
module ast_remote #(
	parameter int BIT_CLKS = 32
) (
	// Clock
	input wire logic core_clk,
	// Line
	input wire logic tx_line,
	output logic rx_line
);
	initial rx_line = 1'b1;
	task automatic send(input logic [8:0] d, input int nb, input logic stp);
		int i;
		@(posedge core_clk);
		for (i = 0; i < nb + 2; i++) begin
			rx_line <= (i == 0) ? 1'b0 : (i == nb + 1) ? stp : d[i - 1];
			repeat (BIT_CLKS) @(posedge core_clk);
		end
		rx_line <= 1'b1;
	endtask
	// Samples at mid-bit so a small phase error between the two ends is harmless.
	task automatic recv(input int nb, output logic [8:0] d, output logic stp, output int w);
		int i;
		d = '0;
		w = 0;
		while (tx_line !== 1'b0 && w < 20000) begin
			@(negedge core_clk);
			w++;
		end
		repeat (BIT_CLKS / 2) @(negedge core_clk);
		for (i = 0; i < nb; i++) begin
			repeat (BIT_CLKS) @(negedge core_clk);
			d[i] = tx_line;
		end
		repeat (BIT_CLKS) @(negedge core_clk);
		stp = tx_line;
	endtask
endmodule

// *** dv/ast_tb_top.sv ***
// Purpose: Self-checking bench for the serial transceiver.
// Assumes: Divisor 2, so one bit lasts 32 core clocks.
// Notes: Register traffic uses AXI4-Lite tasks; the far end is ast_remote.
`timescale 1ns/1ps
module ast_tb_top
	import ast_pkg::*;
;
	localparam int BITC = 32;
	logic core_clk, rstn, rx_pin, tx_pin, tx_oe, irq;
	logic [7:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd_d;
	logic [3:0] s_wstrb;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic [1:0] s_bresp, s_rresp, rd_r;
	logic [8:0] fd;
	logic fs;
	int fw;
	int n_fail = 0;
	int n_compared = 0;
	ast_top dut (.*);
	ast_remote #(.BIT_CLKS(BITC)) far (.core_clk(core_clk), .tx_line(tx_pin), .rx_line(rx_pin));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// ==========================================================
	// Bus and reporting tasks
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Handshakes are judged at the falling edge, where every level is settled.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		int n;
		n = 0;
		@(posedge core_clk);
		{s_awaddr, s_wdata, s_wstrb} <= {a, d, 4'hf};
		{s_awvalid, s_wvalid, s_bready} <= 3'b111;
		do begin
			@(negedge core_clk);
			{ta, tw, tb} = {s_awvalid & s_awready, s_wvalid & s_wready, s_bvalid};
			@(posedge core_clk);
			if (ta) s_awvalid <= 1'b0;
			if (tw) s_wvalid <= 1'b0;
		end while (!tb && ++n < 100);
		s_bready <= 1'b0;
		if (!tb) n_fail++;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ta, tr;
		int n;
		n = 0;
		@(posedge core_clk);
		s_araddr <= a;
		{s_arvalid, s_rready} <= 2'b11;
		do begin
			@(negedge core_clk);
			{ta, tr, rd_d, rd_r} = {s_arvalid & s_arready, s_rvalid, s_rdata, s_rresp};
			@(posedge core_clk);
			if (ta) s_arvalid <= 1'b0;
		end while (!tr && ++n < 100);
		s_rready <= 1'b0;
		if (!tr) n_fail++;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rd(AST_BAUD_OFF);
		check("baud reset", rd_d, {19'h0, AST_BAUD_RST});
		rd(AST_STAT1_OFF);
		check("status reset", rd_d & 32'hc0, 32'hc0);
		rd(8'h1c);
		check("unmapped resp", {30'h0, rd_r}, {30'h0, AST_RESP_SLVERR});
		wr(AST_BAUD_OFF, 32'hffff);
		rd(AST_BAUD_OFF);
		check("baud width", rd_d, 32'h1fff);
		wr(AST_BAUD_OFF, 32'h2);
	endtask
	task automatic t_tx8();
		wr(AST_CTRL2_OFF, 32'h88);
		@(negedge core_clk);
		check("irq empty", 32'(irq), 32'h1);
		rd(AST_STAT1_OFF);
		wr(AST_DATAL_OFF, 32'ha5);
		@(negedge core_clk);
		check("irq filled", 32'(irq), 32'h0);
		far.recv(8, fd, fs, fw);
		check("preamble wait", 32'(fw > 9 * BITC), 32'h1);
		check("tx byte", 32'(fd), 32'ha5);
		check("tx stop", 32'(fs), 32'h1);
		repeat (BITC) @(negedge core_clk);
		check("tx idle", 32'(tx_pin), 32'h1);
		check("irq again", 32'(irq), 32'h1);
	endtask
	task automatic t_tx9();
		int i;
		wr(AST_CTRL1_OFF, 32'h10);
		wr(AST_DATAH_OFF, 32'h40);
		for (i = 0; i < 2; i++) begin
			rd(AST_STAT1_OFF);
			wr(AST_DATAL_OFF, 32'h3c + i);
			far.recv(9, fd, fs, fw);
			check("tx ninth", 32'(fd), 32'h13c + i);
		end
	endtask
	task automatic t_par();
		int i;
		for (i = 0; i < 2; i++) begin
			wr(AST_CTRL1_OFF, 32'h2 | i);
			rd(AST_STAT1_OFF);
			wr(AST_DATAL_OFF, 32'h07);
			far.recv(8, fd, fs, fw);
			check("parity", 32'(fd), (i == 0) ? 32'h87 : 32'h07);
		end
	endtask
	task automatic t_brk();
		int n;
		logic hi;
		hi = 1'b1;
		wr(AST_CTRL1_OFF, 32'h0);
		wr(AST_CTRL2_OFF, 32'h09);
		far.recv(8, fd, fs, fw);
		check("break data", {23'h0, fd, fs}, 32'h0);
		repeat (2 * BITC) @(negedge core_clk);
		check("break repeat", 32'(tx_pin), 32'h0);
		wr(AST_CTRL2_OFF, 32'h08);
		n = 0;
		while (tx_pin !== 1'b1 && n < 800) begin
			@(negedge core_clk);
			n++;
		end
		for (n = 0; n < BITC; n++) begin
			@(negedge core_clk);
			hi = hi & tx_pin;
		end
		check("break end", 32'(hi), 32'h1);
	endtask
	task automatic rx_one(input logic [7:0] c1, input logic [8:0] d, input int nb,
		input logic stp, input logic [31:0] st, input logic [31:0] h);
		int n;
		n = 0;
		wr(AST_CTRL1_OFF, {24'h0, c1});
		far.send(d, nb, stp);
		while (irq !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		check("rx irq", 32'(irq), 32'h1);
		rd(AST_DATAH_OFF);
		check("rx ninth", rd_d & 32'h80, h);
		rd(AST_STAT1_OFF);
		check("rx status", rd_d & 32'h22, st);
		rd(AST_DATAL_OFF);
		check("rx data", rd_d, {24'h0, d[7:0]});
		@(negedge core_clk);
		check("rx irq clear", 32'(irq), 32'h0);
	endtask
	task automatic t_rx();
		rd(AST_STAT1_OFF);
		check("empty before off", rd_d & 32'h80, 32'h80);
		wr(AST_CTRL2_OFF, 32'h24);
		rx_one(8'h00, 9'h05a, 8, 1'b1, 32'h20, 32'h0);
		rx_one(8'h10, 9'h1c3, 9, 1'b1, 32'h20, 32'h80);
		rx_one(8'h00, 9'h000, 8, 1'b0, 32'h22, 32'h0);
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		rstn = 1'b0;
		{s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		t_tx8();
		t_tx9();
		t_par();
		t_brk();
		t_rx();
		finish_test();
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		n_fail++;
		finish_test();
	end
endmodule
